/* File: design/csr_core_regs.sv */
// core special registers: data pointer, stack pointer, working registers and flags over apb
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - pointer low byte at 0x82, rw, reset zero
// - pointer high byte at 0x83, forms 16-bit pointer
// - reset loads stack 0x07, everything else zero
// - push increments stack pointer before the write
// - working register at 0xE0, rw, bit addressable
// - multiply/divide operand at 0xF0, bit addressable
// - flags at 0xD0, low bit read-only
// - carry bit 7 follows arithmetic carry/borrow
// - user flag zero only software changes
// - bank select picks one of four banks
module csr_core_regs (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [csr_pkg::CSR_ADDR_W-1:0] paddr,
    input  wire logic [csr_pkg::CSR_DATA_W-1:0] pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic      [csr_pkg::CSR_DATA_W-1:0] prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic                           stack_store_op,
    input  wire logic                           stack_retrieve_op,
    input  wire logic                           alu_flag_we,
    input  wire logic                           alu_carry,
    input  wire logic                           alu_aux_carry,
    input  wire logic                           alu_range,
    input  wire logic                           work_we,
    input  wire logic [7:0]                     work_wdata,
    input  wire logic                           mulop_we,
    input  wire logic [7:0]                     mulop_wdata,
    input  wire logic                           ptr_we,
    input  wire logic [15:0]                    ptr_wdata,
    output logic      [7:0]                     stack_top_ptr,
    output logic      [15:0]                    data_ptr16,
    output logic      [7:0]                     main_working_reg,
    output logic      [7:0]                     mul_div_operand,
    output logic      [7:0]                     cpu_flags_word,
    output logic      [4:0]                     bank_base_addr
);
    import csr_pkg::*;

    csr_state_t s_q;
    csr_state_t s_d;

    logic          setup_ph;
    logic          wr_acc;
    logic [7:0]    idx;
    logic          aligned;
    logic [7:0]    wbyte;
    logic          wbyte_en;
    csr_stack_op_t stk_op;
    logic [7:0]    bop_idx;
    logic [2:0]    bop_pos;
    logic          bop_val;
    logic [7:0]    bop_tgt;

    // true when the index names one of the registers this block answers for
    function automatic logic idx_mapped(input logic [7:0] i);
        case (i)
            CSR_IDX_STACK, CSR_IDX_PLOW, CSR_IDX_PHIGH,
            CSR_IDX_FLAGS, CSR_IDX_WORK, CSR_IDX_MULOP,
            CSR_IDX_BITOP: idx_mapped = 1'b1;
            default:       idx_mapped = 1'b0;
        endcase
    endfunction : idx_mapped

    // only these three registers take single-bit operations
    function automatic logic idx_bit_ok(input logic [7:0] i);
        idx_bit_ok = (i == CSR_IDX_FLAGS) || (i == CSR_IDX_WORK) || (i == CSR_IDX_MULOP);
    endfunction : idx_bit_ok

    function automatic logic [7:0] flags_of(input csr_state_t s);
        logic [7:0] f;
        f                 = 8'h00;
        f[CSR_FLG_CARRY]  = s.carry_flag;
        f[CSR_FLG_AUX]    = s.aux_carry_flag;
        f[CSR_FLG_USER0]  = s.user_flag_zero;
        f[CSR_FLG_BANKHI] = s.reg_bank_select[1];
        f[CSR_FLG_BANKLO] = s.reg_bank_select[0];
        f[CSR_FLG_RANGE]  = s.signed_range_flag;
        f[CSR_FLG_USER1]  = s.user_flag_one;
        f[CSR_FLG_ODD]    = s.odd_bits_flag;
        flags_of = f;
    endfunction : flags_of

    function automatic logic [7:0] read_of(input csr_state_t s, input logic [7:0] i);
        case (i)
            CSR_IDX_STACK: read_of = s.stack_top_ptr;
            CSR_IDX_PLOW:  read_of = s.ptr_low_byte;
            CSR_IDX_PHIGH: read_of = s.ptr_high_byte;
            CSR_IDX_FLAGS: read_of = flags_of(s);
            CSR_IDX_WORK:  read_of = s.main_working_reg;
            CSR_IDX_MULOP: read_of = s.mul_div_operand;
            default:       read_of = 8'h00;
        endcase
    endfunction : read_of

    assign setup_ph = psel && !penable;
    assign wr_acc   = psel && penable && pwrite;
    assign aligned  = (paddr[1:0] == 2'b00) && (paddr[CSR_ADDR_W-1:10] == 2'b00);
    assign idx      = paddr[9:2];
    assign wbyte    = pwdata[7:0];
    assign wbyte_en = wr_acc && pstrb[0] && aligned;
    assign stk_op   = csr_stack_op_t'({stack_retrieve_op, stack_store_op});
    assign bop_idx  = pwdata[CSR_BOP_IDX_LO +: 8];
    assign bop_pos  = pwdata[CSR_BOP_POS_LO +: 3];
    assign bop_val  = pwdata[CSR_BOP_VAL];

    always_comb begin
        s_d     = s_q;
        bop_tgt = 8'h00;

        // software writes first; datapath events below take precedence
        if (wbyte_en) begin
            case (idx)
                CSR_IDX_STACK: s_d.stack_top_ptr = wbyte;
                CSR_IDX_PLOW:  s_d.ptr_low_byte  = wbyte;
                CSR_IDX_PHIGH: s_d.ptr_high_byte = wbyte;
                CSR_IDX_WORK:  s_d.main_working_reg = wbyte;
                CSR_IDX_MULOP: s_d.mul_div_operand  = wbyte;
                CSR_IDX_FLAGS: begin
                    // odd-bits flag is not writable; it follows the working register
                    s_d.carry_flag        = wbyte[CSR_FLG_CARRY];
                    s_d.aux_carry_flag    = wbyte[CSR_FLG_AUX];
                    s_d.user_flag_zero    = wbyte[CSR_FLG_USER0];
                    s_d.reg_bank_select   = wbyte[CSR_FLG_BANKHI:CSR_FLG_BANKLO];
                    s_d.signed_range_flag = wbyte[CSR_FLG_RANGE];
                    s_d.user_flag_one     = wbyte[CSR_FLG_USER1];
                end
                CSR_IDX_BITOP: begin
                    if (idx_bit_ok(bop_idx)) begin
                        bop_tgt          = read_of(s_q, bop_idx);
                        bop_tgt[bop_pos] = bop_val;
                        case (bop_idx)
                            CSR_IDX_WORK:  s_d.main_working_reg = bop_tgt;
                            CSR_IDX_MULOP: s_d.mul_div_operand  = bop_tgt;
                            CSR_IDX_FLAGS: begin
                                s_d.carry_flag        = bop_tgt[CSR_FLG_CARRY];
                                s_d.aux_carry_flag    = bop_tgt[CSR_FLG_AUX];
                                s_d.user_flag_zero    = bop_tgt[CSR_FLG_USER0];
                                s_d.reg_bank_select   = bop_tgt[CSR_FLG_BANKHI:CSR_FLG_BANKLO];
                                s_d.signed_range_flag = bop_tgt[CSR_FLG_RANGE];
                                s_d.user_flag_one     = bop_tgt[CSR_FLG_USER1];
                            end
                            default: s_d.user_flag_one = s_d.user_flag_one;
                        endcase
                    end
                end
                default: s_d.slverr = s_d.slverr;
            endcase
        end

        // datapath wins a same-cycle collision with a software write
        if (work_we) begin
            s_d.main_working_reg = work_wdata;
        end
        if (mulop_we) begin
            s_d.mul_div_operand = mulop_wdata;
        end
        if (ptr_we) begin
            s_d.ptr_high_byte = ptr_wdata[15:8];
            s_d.ptr_low_byte  = ptr_wdata[7:0];
        end
        if (alu_flag_we) begin
            s_d.carry_flag        = alu_carry;
            s_d.aux_carry_flag    = alu_aux_carry;
            s_d.signed_range_flag = alu_range;
        end

        // a push and a pop in one cycle cancel; the pointer keeps its value
        case (stk_op)
            CSR_STK_PUSH: s_d.stack_top_ptr = s_q.stack_top_ptr + 8'h01;
            CSR_STK_POP:  s_d.stack_top_ptr = s_q.stack_top_ptr - 8'h01;
            CSR_STK_BOTH: s_d.stack_top_ptr = s_q.stack_top_ptr;
            default:      s_d.stack_top_ptr = s_d.stack_top_ptr;
        endcase

        // tracks the next working value so it never lags the register by a cycle
        s_d.odd_bits_flag = ^s_d.main_working_reg;

        // read data and error are captured in the setup phase, giving a zero-wait access phase
        if (setup_ph) begin
            s_d.slverr = !(aligned && idx_mapped(idx));
            s_d.rdata  = {24'h000000, (aligned ? read_of(s_q, idx) : 8'h00)};
            if (pwrite || !aligned) begin
                s_d.rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q                   <= '0;
            s_q.stack_top_ptr     <= CSR_RST_STACK;
            s_q.ptr_low_byte      <= CSR_RST_ZERO;
            s_q.ptr_high_byte     <= CSR_RST_ZERO;
            s_q.main_working_reg  <= CSR_RST_ZERO;
            s_q.mul_div_operand   <= CSR_RST_ZERO;
        end else begin
            s_q <= s_d;
        end
    end

    assign pready           = 1'b1;
    assign prdata           = s_q.rdata;
    assign pslverr          = psel && penable && s_q.slverr;
    assign stack_top_ptr    = s_q.stack_top_ptr;
    assign data_ptr16       = {s_q.ptr_high_byte, s_q.ptr_low_byte};
    assign main_working_reg = s_q.main_working_reg;
    assign mul_div_operand  = s_q.mul_div_operand;
    assign cpu_flags_word   = flags_of(s_q);
    // bank base stays within 0x00..0x1F by construction
    assign bank_base_addr   = CSR_BANK_FIRST
                            | {s_q.reg_bank_select, 3'b000};

endmodule : csr_core_regs

`default_nettype wire

/* File: design/csr_pkg.sv */
// package for the core special register block: register indexes, fields, reset values
package csr_pkg;

    // register indexes in the special-function space; byte address is four times the index
    localparam logic [7:0] CSR_IDX_STACK = 8'h81;
    localparam logic [7:0] CSR_IDX_PLOW  = 8'h82;
    localparam logic [7:0] CSR_IDX_PHIGH = 8'h83;
    localparam logic [7:0] CSR_IDX_FLAGS = 8'hD0;
    localparam logic [7:0] CSR_IDX_WORK  = 8'hE0;
    localparam logic [7:0] CSR_IDX_MULOP = 8'hF0;
    localparam logic [7:0] CSR_IDX_BITOP = 8'hA0;

    localparam int CSR_ADDR_W = 12;
    localparam int CSR_DATA_W = 32;

    // reset values
    localparam logic [7:0] CSR_RST_STACK = 8'h07;
    localparam logic [7:0] CSR_RST_ZERO  = 8'h00;

    // flag word bit positions
    localparam int CSR_FLG_CARRY  = 7;
    localparam int CSR_FLG_AUX    = 6;
    localparam int CSR_FLG_USER0  = 5;
    localparam int CSR_FLG_BANKHI = 4;
    localparam int CSR_FLG_BANKLO = 3;
    localparam int CSR_FLG_RANGE  = 2;
    localparam int CSR_FLG_USER1  = 1;
    localparam int CSR_FLG_ODD    = 0;

    // bit operation word fields
    localparam int CSR_BOP_IDX_LO = 0;
    localparam int CSR_BOP_POS_LO = 8;
    localparam int CSR_BOP_VAL    = 11;

    // register bank layout: four banks of eight bytes from location 0x00
    localparam int         CSR_BANK_SHIFT = 3;
    localparam logic [4:0] CSR_BANK_FIRST = 5'h00;
    localparam logic [4:0] CSR_BANK_LAST  = 5'h1F;

    typedef enum logic [1:0] {
        CSR_STK_HOLD = 2'b00,
        CSR_STK_PUSH = 2'b01,
        CSR_STK_POP  = 2'b10,
        CSR_STK_BOTH = 2'b11
    } csr_stack_op_t;

    typedef struct packed {
        logic [7:0]  stack_top_ptr;
        logic [7:0]  ptr_low_byte;
        logic [7:0]  ptr_high_byte;
        logic [7:0]  main_working_reg;
        logic [7:0]  mul_div_operand;
        logic        carry_flag;
        logic        aux_carry_flag;
        logic        user_flag_zero;
        logic [1:0]  reg_bank_select;
        logic        signed_range_flag;
        logic        user_flag_one;
        logic        odd_bits_flag;
        logic [31:0] rdata;
        logic        slverr;
    } csr_state_t;

endpackage : csr_pkg

/* File: test/csr_core_regs_monitor.sv */
// assertion checker for the core special register block
`timescale 1ns/1ps
`default_nettype none
module csr_core_regs_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        stack_store_op,
    input wire logic        stack_retrieve_op,
    input wire logic        alu_flag_we,
    input wire logic        alu_carry,
    input wire logic        alu_aux_carry,
    input wire logic        work_we,
    input wire logic        ptr_we,
    input wire logic [7:0]  stack_top_ptr,
    input wire logic [15:0] data_ptr16,
    input wire logic [7:0]  main_working_reg,
    input wire logic [7:0]  cpu_flags_word,
    input wire logic [4:0]  bank_base_addr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    assign wr = psel && penable && pwrite;
    push_incr_a: assert property (
        stack_store_op && !stack_retrieve_op |=> stack_top_ptr == 8'($past(stack_top_ptr) + 1))
        else $error("push did not raise the stack pointer by one");
    pop_decr_a: assert property (
        stack_retrieve_op && !stack_store_op |=> stack_top_ptr == 8'($past(stack_top_ptr) - 1))
        else $error("pop did not lower the stack pointer by one");
    reset_vals_a: assert property (
        $rose(presetn) |-> stack_top_ptr == 8'h07 && data_ptr16 == 16'h0000
            && main_working_reg == 8'h00 && cpu_flags_word == 8'h00)
        else $error("wrong values after reset");
    odd_flag_a: assert property (cpu_flags_word[0] == ^main_working_reg)
        else $error("odd bit flag does not follow working register");
    alu_flags_a: assert property (
        alu_flag_we |=> cpu_flags_word[7:6] == {$past(alu_carry), $past(alu_aux_carry)})
        else $error("carry flags not loaded from arithmetic result");
    bank_base_a: assert property (bank_base_addr == {cpu_flags_word[4:3], 3'b000})
        else $error("bank base does not match bank select");
    ptr_low_a: assert property (
        wr && paddr == 12'h208 && !ptr_we |=> data_ptr16[7:0] == $past(pwdata[7:0]))
        else $error("pointer low byte write lost");
    user_flag_a: assert property (!wr |=> $stable(cpu_flags_word[5]))
        else $error("user flag zero changed without software");
    work_wr_a: assert property (
        wr && paddr == 12'h380 && !work_we |=> main_working_reg == $past(pwdata[7:0]))
        else $error("working register write lost");
    cover property (stack_store_op);
    cover property (stack_retrieve_op);
    cover property (alu_flag_we);
endmodule : csr_core_regs_monitor
bind csr_core_regs csr_core_regs_monitor u_csr_core_regs_monitor (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .stack_store_op, .stack_retrieve_op, .alu_flag_we,
    .alu_carry, .alu_aux_carry, .work_we, .ptr_we, .stack_top_ptr, .data_ptr16,
    .main_working_reg, .cpu_flags_word, .bank_base_addr);
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench for the core special register block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import csr_pkg::*;
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [6:0]  dpv     = 7'h00;
    logic [7:0]  wwd     = 8'h00;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, er;
    logic [7:0]  stack_top_ptr, main_working_reg, cpu_flags_word, mul_div_operand;
    logic [15:0] data_ptr16;
    logic [4:0]  bank_base_addr;
    int          fail_count = 0;
    int          compares   = 0;
    int          cyc        = 0;
    // stack, pointer low/high, flags, working, operand
    logic [7:0]  ix [6] = '{CSR_IDX_STACK, CSR_IDX_PLOW, CSR_IDX_PHIGH, CSR_IDX_FLAGS,
                            CSR_IDX_WORK, CSR_IDX_MULOP};
    logic [7:0]  wv [6] = '{8'h5A, 8'h3C, 8'hC3, 8'hFF, 8'h81, 8'h7E};

    // strobe and data tied off: operand and pointer loads are reached over the bus instead
    csr_core_regs u_csr_core_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr, .stack_store_op(dpv[6]),
        .stack_retrieve_op(dpv[5]), .alu_flag_we(dpv[4]), .alu_carry(dpv[3]),
        .alu_aux_carry(dpv[2]), .alu_range(dpv[1]), .work_we(dpv[0]), .work_wdata(wwd),
        .mulop_we(1'b0), .mulop_wdata(8'h00), .ptr_we(1'b0), .ptr_wdata(16'h0000),
        .stack_top_ptr, .data_ptr16, .main_working_reg, .mul_div_operand, .cpu_flags_word,
        .bank_base_addr);

    initial forever #20 pclk = ~pclk;

    always @(posedge pclk) begin
        cyc++;
        if (cyc > 2000) begin
            fail_count++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    // one edge idles after each transfer so the next setup never lands in the same step
    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d, input int o = 0);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, i, 2'b00} + 12'(o);
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // datapath strobes {push, pop, flag load, carry, aux, range, work load}
    task automatic dp(input logic [6:0] v, input logic [7:0] d = 8'h00);
        dpv <= v;
        wwd <= d;
        @(posedge pclk);
        dpv <= 7'h00;
        @(posedge pclk);
    endtask : dp

    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ix[i], 8'h00);
            chk(rd, (i == 0) ? 32'h07 : 32'h0);
        end
        $display("test reset done");
    endtask : t_reset

    task automatic t_rw();
        for (int i = 0; i < 6; i++) apb(1'b1, ix[i], wv[i]);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, ix[i], 8'h00);
            chk(rd, (i == 3) ? 32'hFE : {24'h0, wv[i]});
        end
        chk({16'h0, data_ptr16}, 32'hC33C);
        chk({27'h0, bank_base_addr}, 32'h18);
        chk({24'h0, mul_div_operand}, 32'h7E);
        apb(1'b1, 8'h40, 8'h11);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, CSR_IDX_STACK, 8'h00, 1);
        chk({31'h0, er}, 32'h1);
        $display("test read write done");
    endtask : t_rw

    task automatic t_stack();
        dp(7'h40);
        chk({24'h0, stack_top_ptr}, 32'h5B);
        dp(7'h20);
        dp(7'h20);
        chk({24'h0, stack_top_ptr}, 32'h59);
        dp(7'h60);
        chk({24'h0, stack_top_ptr}, 32'h59);
        apb(1'b1, CSR_IDX_STACK, 8'hFF);
        dp(7'h40);
        chk({24'h0, stack_top_ptr}, 32'h00);
        dp(7'h20);
        chk({24'h0, stack_top_ptr}, 32'hFF);
        $display("test stack done");
    endtask : t_stack

    task automatic t_alu();
        dp(7'h14);
        chk({24'h0, cpu_flags_word}, 32'h7A);
        dp(7'h1A);
        chk({24'h0, cpu_flags_word}, 32'hBE);
        dp(7'h01, 8'h07);
        chk({24'h0, main_working_reg}, 32'h07);
        chk({24'h0, cpu_flags_word}, 32'hBF);
        $display("test flags done");
    endtask : t_alu

    // single-bit operations: {value, bit, target index}
    task automatic t_bitop();
        apb(1'b1, CSR_IDX_BITOP, 32'h00000FE0);
        chk({24'h0, main_working_reg}, 32'h87);
        apb(1'b1, CSR_IDX_BITOP, 32'h000005D0);
        chk({24'h0, cpu_flags_word}, 32'h9E);
        $display("test bit operation done");
    endtask : t_bitop

    task automatic test_done();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_rw();
        t_stack();
        t_alu();
        t_bitop();
        test_done();
    end
endmodule : tb
`default_nettype wire
